// ---- shared/watchdog_defines.vh ----
// Purpose: Constants for the watchdog and reset-cause flag block
// Assumes: Included by its bare name from the core design file
// Notes: Register indices are multiplied by four to form byte addresses
`ifndef WATCHDOG_DEFINES_VH
`define WATCHDOG_DEFINES_VH

// --------------------------------------------------------------------
// Register indices and byte addresses
// --------------------------------------------------------------------
`define WD_CTRL_INDEX 8'h21
`define RST_FLAGS_INDEX 8'h34
`define WD_CTRL_ADDR 12'h084
`define RST_FLAGS_ADDR 12'h0D0

// --------------------------------------------------------------------
// Control and status field positions
// --------------------------------------------------------------------
`define WD_IRQ_FLAG_BIT 7
`define WD_IRQ_ENABLE_BIT 6
`define WD_PRESCALE_HI_BIT 5
`define WD_CHANGE_ENABLE_BIT 4
`define WD_ENABLE_BIT 3

// Reset-cause field positions
`define WD_CAUSE_BIT 3
`define BROWNOUT_CAUSE_BIT 2
`define EXT_CAUSE_BIT 1
`define POWERON_CAUSE_BIT 0

// --------------------------------------------------------------------
// Reset values
// --------------------------------------------------------------------
`define WD_PRESCALE_RESET 4'h0
`define RST_FLAGS_RESET 4'h1

// --------------------------------------------------------------------
// Timing
// --------------------------------------------------------------------
`define CLK_FREQ_HZ 50000000
`define WD_OSC_FREQ_HZ 128000
`define WD_SEQ_CYCLES 3'h4
`define WD_BASE_CYCLES 21'h000800
`define WD_PRESCALE_MAX 4'h9
`define RESET_DELAY_DEFAULT 16

`endif

// ---- core/watchdog_and_reset_flags.v ----
// Purpose: Watchdog timer with safety levels and reset-cause flags behind AXI4-Lite
// Assumes: One 50 MHz clock; aresetn stands for the power-on reset
// Notes: The 128 kHz watchdog rate is a one-cycle enable from a divider
//   TICK_DIVISOR sets the system clocks per watchdog tick
//   Reserved prescale codes are stored as written but time as the longest
//   A chip reset keeps the cause flags; only aresetn resets them
//   The change window counts four system clocks from the opening write
//
// What this block does
// - Watchdog counter advances on dedicated 128 kHz tick
// - Restart instruction clears the watchdog counter
// - Disable or chip reset clears counter
// - Ten time-outs; reset-mode expiry resets chip
// - One-cycle reset pulse, delay starts after it
// - Fuse selects safety level and initial enable
// - Level 1: writing enable one enables at once
// - Level 1 disable needs four-cycle timed sequence
// - Level 2: enable reads one, prescaler timed
// - Level 2 prescaler write in window, enable ignored
// - Watchdog, brown-out, external flags set; zero clears
// - Power-on flag set at power-on; zero clears
// - Reset-cause bits 7 to 4 read zero
// - Interrupt flag set; vector or one clears
// - Interrupt request needs flag, enable, global enable
// - Irq enable without enable: interrupt, no reset
// - Both set: interrupt, hardware clears irq enable
// - Brown-out asserts reset at once, delayed release
// - Change enable clears itself four cycles later
// - Level 1: watchdog cause flag forces enable
// - Prescale code 0 gives 2K, doubling to 1024K
`include "watchdog_defines.vh"

module watchdog_and_reset_flags #(
  parameter RESET_DELAY_CYCLES = `RESET_DELAY_DEFAULT,
  parameter TICK_DIVISOR = `CLK_FREQ_HZ / `WD_OSC_FREQ_HZ
) (
  input wire aclk,
  input wire aresetn,
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire safety_level_fuse,
  input wire wd_restart_instr,
  input wire irq_vector_taken,
  input wire cpu_global_irq_enable,
  input wire brownout_enable,
  input wire brownout_low,
  input wire ext_reset_req,
  output reg wd_irq_request,
  output reg wd_reset_pulse,
  output reg chip_reset
);

  // ------------------------------------------------------------------
  // Derived constants
  // ------------------------------------------------------------------
  // Divider reload and delay end point, cut to the counter widths
  localparam integer TICK_LAST_INT = TICK_DIVISOR - 1;
  localparam integer DELAY_LAST_INT = RESET_DELAY_CYCLES - 1;
  localparam [8:0] TICK_DIV = TICK_LAST_INT[8:0];
  localparam [15:0] DELAY_LAST = DELAY_LAST_INT[15:0];

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  // Counters, control fields and cause flags
  reg [8:0] tick_cnt;
  reg wd_tick;
  reg [19:0] wd_count;
  reg wd_irq_flag;
  reg wd_irq_enable;
  reg wd_enable_bit;
  reg [3:0] wd_prescale_sel;
  reg [2:0] seq_cnt;
  reg wd_reset_cause_flag;
  reg brownout_cause_flag;
  reg ext_reset_cause_flag;
  reg poweron_cause_flag;
  reg [15:0] delay_cnt;
  reg delay_run;

  // Effective enable as software and the counter see it
  wire level2 = safety_level_fuse;
  wire wd_enable_eff = level2 | wd_enable_bit | wd_reset_cause_flag;
  wire wd_running = wd_enable_eff | wd_irq_enable;
  wire seq_open = (seq_cnt != 3'h0);

  // Time-out length in ticks; reserved codes fall to the longest
  wire [3:0] sel_eff = (wd_prescale_sel > `WD_PRESCALE_MAX) ? `WD_PRESCALE_MAX :
                       wd_prescale_sel;
  wire [20:0] limit = `WD_BASE_CYCLES << sel_eff;
  wire [19:0] last_count = limit[19:0] - 20'h00001;
  wire wd_timeout = wd_tick & wd_running & (wd_count == last_count) & ~chip_reset;

  // Watchdog reset and interrupt events, and brown-out
  wire wd_reset_event = wd_timeout & wd_enable_eff & ~wd_irq_enable;
  wire wd_irq_event = wd_timeout & wd_irq_enable;
  wire bo_active = brownout_enable & brownout_low;

  // ------------------------------------------------------------------
  // AXI4-Lite write decode
  // ------------------------------------------------------------------
  // Write strobes per register; lane 0 carries the byte
  wire wr_fire = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready;
  wire wr_lane0 = wr_fire & s_axi_wstrb[0];
  wire wr_ctrl = wr_lane0 & (s_axi_awaddr == `WD_CTRL_ADDR);
  wire wr_flags = wr_lane0 & (s_axi_awaddr == `RST_FLAGS_ADDR);
  wire wr_mapped = (s_axi_awaddr == `WD_CTRL_ADDR) | (s_axi_awaddr == `RST_FLAGS_ADDR);
  wire [7:0] wbyte = s_axi_wdata[7:0];
  wire [3:0] wsel = {wbyte[`WD_PRESCALE_HI_BIT], wbyte[2:0]};
  wire w_ce = wbyte[`WD_CHANGE_ENABLE_BIT];
  wire w_en = wbyte[`WD_ENABLE_BIT];
  wire seq_start = wr_ctrl & w_ce & w_en;
  wire seq_commit = wr_ctrl & ~w_ce & seq_open;

  // Register read views
  wire [7:0] ctrl_view = {wd_irq_flag, wd_irq_enable, wd_prescale_sel[3], seq_open,
                          wd_enable_eff, wd_prescale_sel[2:0]};
  wire [7:0] flags_view = {4'h0, wd_reset_cause_flag, brownout_cause_flag,
                           ext_reset_cause_flag, poweron_cause_flag};

  // ------------------------------------------------------------------
  // Watchdog rate divider
  // ------------------------------------------------------------------
  // One-cycle tick every TICK_DIVISOR system clocks
  always @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt <= 9'h000;
      wd_tick <= 1'b0;
    end else if (tick_cnt == TICK_DIV) begin
      tick_cnt <= 9'h000;
      wd_tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 9'h001;
      wd_tick <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Watchdog counter
  // ------------------------------------------------------------------
  // Tick and events share the system clock, so no event is lost or doubled
  always @(posedge aclk) begin
    if (!aresetn) begin
      wd_count <= 20'h00000;
    end else if (chip_reset || !wd_running) begin
      wd_count <= 20'h00000;
    end else if (wd_restart_instr) begin
      wd_count <= 20'h00000;
    end else if (wd_timeout) begin
      wd_count <= 20'h00000;
    end else if (wd_tick) begin
      wd_count <= wd_count + 20'h00001;
    end
  end

  // ------------------------------------------------------------------
  // Timed-sequence window
  // ------------------------------------------------------------------
  // Change enable stays readable for four cycles then closes
  always @(posedge aclk) begin
    if (!aresetn || chip_reset) begin
      seq_cnt <= 3'h0;
    end else if (seq_start) begin
      seq_cnt <= `WD_SEQ_CYCLES;
    end else if (seq_commit) begin
      seq_cnt <= 3'h0;
    end else if (seq_open) begin
      seq_cnt <= seq_cnt - 3'h1;
    end
  end

  // ------------------------------------------------------------------
  // Control and status register
  // ------------------------------------------------------------------
  // Enable, prescaler, interrupt enable and interrupt flag
  always @(posedge aclk) begin
    if (!aresetn || chip_reset) begin
      wd_enable_bit <= 1'b0;
      wd_prescale_sel <= `WD_PRESCALE_RESET;
      wd_irq_enable <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        wd_irq_enable <= wbyte[`WD_IRQ_ENABLE_BIT];
        // Level 1 takes the prescaler freely; level 2 only on commit
        if (!level2) begin
          wd_prescale_sel <= wsel;
          if (w_en) begin
            wd_enable_bit <= 1'b1;
          end else if (seq_commit) begin
            wd_enable_bit <= 1'b0;
          end
        end else if (seq_commit) begin
          wd_prescale_sel <= wsel;
        end
      end
      if (wd_irq_event && wd_enable_eff) begin
        wd_irq_enable <= 1'b0;
      end
      // Level 1: a set watchdog cause flag holds the enable bit on
      if (!level2 && wd_reset_cause_flag) begin
        wd_enable_bit <= 1'b1;
      end
    end
  end

  // Interrupt flag: hardware set wins over any clear
  always @(posedge aclk) begin
    if (!aresetn || chip_reset) begin
      wd_irq_flag <= 1'b0;
    end else if (wd_irq_event) begin
      wd_irq_flag <= 1'b1;
    end else if (irq_vector_taken) begin
      wd_irq_flag <= 1'b0;
    end else if (wr_ctrl && wbyte[`WD_IRQ_FLAG_BIT]) begin
      wd_irq_flag <= 1'b0;
    end
  end

  // Interrupt request to the processor
  always @(posedge aclk) begin
    if (!aresetn) begin
      wd_irq_request <= 1'b0;
    end else begin
      wd_irq_request <= wd_irq_flag & wd_irq_enable & cpu_global_irq_enable;
    end
  end

  // ------------------------------------------------------------------
  // Reset generation
  // ------------------------------------------------------------------
  // One-cycle watchdog reset pulse
  always @(posedge aclk) begin
    if (!aresetn) begin
      wd_reset_pulse <= 1'b0;
    end else begin
      wd_reset_pulse <= wd_reset_event;
    end
  end

  // Chip reset held by sources, then stretched by the delay counter
  always @(posedge aclk) begin
    if (!aresetn) begin
      chip_reset <= 1'b0;
      delay_run <= 1'b0;
      delay_cnt <= 16'h0000;
    end else if (bo_active || ext_reset_req || wd_reset_event) begin
      chip_reset <= 1'b1;
      delay_run <= 1'b0;
      delay_cnt <= 16'h0000;
    end else if (chip_reset && !delay_run && !wd_reset_pulse) begin
      delay_run <= 1'b1;
      delay_cnt <= 16'h0000;
    end else if (delay_run) begin
      if (delay_cnt == DELAY_LAST) begin
        delay_run <= 1'b0;
        chip_reset <= 1'b0;
      end else begin
        delay_cnt <= delay_cnt + 16'h0001;
      end
    end
  end

  // ------------------------------------------------------------------
  // Reset-cause flags
  // ------------------------------------------------------------------
  // Sources set their flag; a set in the cycle of a clearing write wins
  always @(posedge aclk) begin
    if (!aresetn) begin
      {wd_reset_cause_flag, brownout_cause_flag, ext_reset_cause_flag,
       poweron_cause_flag} <= `RST_FLAGS_RESET;
    end else begin
      if (wd_reset_event) begin
        wd_reset_cause_flag <= 1'b1;
      end else if (wr_flags && !wbyte[`WD_CAUSE_BIT]) begin
        wd_reset_cause_flag <= 1'b0;
      end
      if (bo_active) begin
        brownout_cause_flag <= 1'b1;
      end else if (wr_flags && !wbyte[`BROWNOUT_CAUSE_BIT]) begin
        brownout_cause_flag <= 1'b0;
      end
      if (ext_reset_req) begin
        ext_reset_cause_flag <= 1'b1;
      end else if (wr_flags && !wbyte[`EXT_CAUSE_BIT]) begin
        ext_reset_cause_flag <= 1'b0;
      end
      // Power-on flag clears only by software
      if (wr_flags && !wbyte[`POWERON_CAUSE_BIT]) begin
        poweron_cause_flag <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // AXI4-Lite slave
  // ------------------------------------------------------------------
  // Write: address and data taken together, response next cycle
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      // Response follows the handshake; ready waits for both valids
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_mapped ? 2'h0 : 2'h2;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end else if (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready) begin
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Read: address taken, data one cycle later
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_arready <= 1'b0;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        // Decode the byte address of the register
        case (s_axi_araddr)
          `WD_CTRL_ADDR: begin
            s_axi_rdata <= {24'h000000, ctrl_view};
            s_axi_rresp <= 2'h0;
          end
          `RST_FLAGS_ADDR: begin
            s_axi_rdata <= {24'h000000, flags_view};
            s_axi_rresp <= 2'h0;
          end
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end else if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // watchdog_and_reset_flags

// ---- tb/watchdog_and_reset_flags_chk.sv ----
// Purpose: Port assertions for the watchdog and reset-cause block
// Assumes: One clock domain, synchronous active-low reset
// Notes: Bound to every instance of the design
module watchdog_and_reset_flags_chk #(
  parameter RESET_DELAY_CYCLES = 16
) (
  input wire aclk,
  input wire aresetn,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire cpu_global_irq_enable,
  input wire brownout_enable,
  input wire brownout_low,
  input wire ext_reset_req,
  input wire wd_irq_request,
  input wire wd_reset_pulse,
  input wire chip_reset
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ----------
  // Helpers
  // ----------
  wire src = ext_reset_req || (brownout_enable && brownout_low);
  reg [11:0] rd_addr;
  reg [7:0] quiet;
  // Last read address, cycles without a reset source
  always @(posedge aclk) begin
    if (!aresetn) begin
      rd_addr <= 12'h000;
      quiet <= 8'h00;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        rd_addr <= s_axi_araddr;
      end
      quiet <= src ? 8'h00 : (quiet == 8'hFF ? quiet : quiet + 8'h01);
    end
  end
  // ----------
  // Properties
  // ----------
  property p_pulse_one;
    wd_reset_pulse |=> !wd_reset_pulse;
  endproperty
  a_pulse_one: assert property (p_pulse_one) else $error("reset pulse too long");
  property p_pulse_reset;
    wd_reset_pulse |-> chip_reset;
  endproperty
  a_pulse_reset: assert property (p_pulse_reset) else $error("pulse without reset");
  property p_src_reset;
    src |=> chip_reset;
  endproperty
  a_src_reset: assert property (p_src_reset) else $error("source not resetting");
  property p_rise_cause;
    $rose(chip_reset) |-> $past(src) || wd_reset_pulse;
  endproperty
  a_rise_cause: assert property (p_rise_cause) else $error("reset without cause");
  property p_release;
    $fell(chip_reset) |-> quiet >= RESET_DELAY_CYCLES;
  endproperty
  a_release: assert property (p_release) else $error("reset released early");
  property p_irq_global;
    !cpu_global_irq_enable |=> !wd_irq_request;
  endproperty
  a_irq_global: assert property (p_irq_global) else $error("irq without global");
  property p_flags_upper;
    s_axi_rvalid && rd_addr == 12'h0D0 |-> s_axi_rdata[7:4] == 4'h0;
  endproperty
  a_flags_upper: assert property (p_flags_upper) else $error("flag upper bits set");
  property p_rdata_upper;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
  endproperty
  a_rdata_upper: assert property (p_rdata_upper) else $error("read data upper set");
  property p_bvalid_drop;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_bvalid_drop: assert property (p_bvalid_drop) else $error("bvalid stuck");
  c_ext: cover property (ext_reset_req ##1 chip_reset);
  c_fell: cover property ($fell(chip_reset));
  c_flags: cover property (s_axi_rvalid && rd_addr == 12'h0D0);
endmodule // watchdog_and_reset_flags_chk

bind watchdog_and_reset_flags watchdog_and_reset_flags_chk #(
  .RESET_DELAY_CYCLES(RESET_DELAY_CYCLES)
) i_chk (.aclk, .aresetn, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_bvalid, .s_axi_bready, .cpu_global_irq_enable, .brownout_enable,
  .brownout_low, .ext_reset_req, .wd_irq_request, .wd_reset_pulse, .chip_reset);

// ---- tb/watchdog_and_reset_flags_tb.sv ----
// Purpose: Self-checking bench for the watchdog and reset-cause block
// Assumes: 50 MHz clock, short reset stretch
// Notes: Watchdog ticks every clock so time-outs fit in the run
`include "watchdog_defines.vh"
module watchdog_and_reset_flags_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DLY = 2;
  localparam int WD0 = 2048; // Ticks to a code-0 time-out
  localparam logic [11:0] CT = `WD_CTRL_ADDR;
  localparam logic [11:0] FL = `RST_FLAGS_ADDR;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata;
  logic [3:0] s_axi_wstrb;
  logic safety_level_fuse, wd_restart_instr, irq_vector_taken, cpu_global_irq_enable;
  logic brownout_enable, brownout_low, ext_reset_req;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire wd_irq_request, wd_reset_pulse, chip_reset;
  int num_errors = 0;
  int tests_run = 0;
  watchdog_and_reset_flags #(.RESET_DELAY_CYCLES(DLY), .TICK_DIVISOR(1))
    i_watchdog_and_reset_flags (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .safety_level_fuse, .wd_restart_instr, .irq_vector_taken,
    .cpu_global_irq_enable, .brownout_enable, .brownout_low, .ext_reset_req,
    .wd_irq_request, .wd_reset_pulse, .chip_reset);
  // ----------
  // Tasks
  // ----------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic restart;
    wd_restart_instr <= 1'b1;
    tick(1);
    wd_restart_instr <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do @(posedge aclk); while (!(s_axi_awready === 1'b1 && s_axi_wready === 1'b1));
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    check("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
  endtask
  task automatic rd(input string what, input logic [11:0] a, input logic [7:0] exp,
                    input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    check(what, s_axi_rdata, {24'h000000, exp});
    check({what, " resp"}, {30'h0, s_axi_rresp}, {30'h0, er});
  endtask
  task automatic wrap_up;
    if (num_errors == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ----------
  // Clock, watchdog, sequence
  // ----------
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  initial begin
    tick(30000);
    num_errors++;
    wrap_up();
  end
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {safety_level_fuse, wd_restart_instr, irq_vector_taken, cpu_global_irq_enable} = 4'h0;
    {brownout_enable, brownout_low, ext_reset_req, aresetn} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
    s_axi_wstrb = 4'hF;
    tick(12);
    aresetn <= 1'b1;
    tick(1);
    rd("flags", FL, 8'h01, 2'h0);
    rd("ctrl", CT, 8'h00, 2'h0);
    wr(FL, 8'h00, 2'h0);
    rd("flags clr", FL, 8'h00, 2'h0);
    wr(12'h100, 8'hFF, 2'h2);
    rd("unmapped", 12'h100, 8'h00, 2'h2);
    // External reset and stretch
    ext_reset_req <= 1'b1;
    tick(3);
    check("ext", chip_reset, 1'b1);
    ext_reset_req <= 1'b0;
    tick(1);
    check("stretch", chip_reset, 1'b1);
    tick(DLY + 4);
    check("release", chip_reset, 1'b0);
    rd("ext flag", FL, 8'h02, 2'h0);
    // Brown-out, disabled then enabled
    brownout_low <= 1'b1;
    tick(3);
    check("bod off", chip_reset, 1'b0);
    brownout_enable <= 1'b1;
    tick(2);
    check("bod on", chip_reset, 1'b1);
    brownout_low <= 1'b0;
    tick(DLY + 5);
    rd("bod flag", FL, 8'h06, 2'h0);
    wr(FL, 8'h04, 2'h0);
    rd("flag bit", FL, 8'h04, 2'h0);
    wr(FL, 8'h00, 2'h0);
    // Restart, vector, interrupt gating
    {wd_restart_instr, irq_vector_taken, cpu_global_irq_enable} <= 3'b111;
    tick(1);
    {wd_restart_instr, irq_vector_taken} <= 2'b00;
    wr(CT, 8'h40, 2'h0);
    rd("irq en", CT, 8'h40, 2'h0);
    check("no flag irq", wd_irq_request, 1'b0);
    cpu_global_irq_enable <= 1'b0;
    // Safety level 1 sequences
    wr(CT, 8'h08, 2'h0);
    rd("enable", CT, 8'h08, 2'h0);
    wr(CT, 8'h00, 2'h0);
    rd("no seq", CT, 8'h08, 2'h0);
    wr(CT, 8'h18, 2'h0);
    wr(CT, 8'h00, 2'h0);
    rd("seq off", CT, 8'h00, 2'h0);
    wr(CT, 8'h21, 2'h0);
    rd("presc", CT, 8'h21, 2'h0);
    wr(CT, 8'h18, 2'h0);
    tick(6);
    wr(CT, 8'h00, 2'h0);
    rd("closed", CT, 8'h08, 2'h0);
    // Watchdog reset: restart, expiry, pulse, stretch, forced enable
    restart();
    tick(WD0 - 1);
    check("early", {wd_reset_pulse, chip_reset}, 2'b00);
    tick(2);
    check("expiry", {wd_reset_pulse, chip_reset}, 2'b11);
    tick(1);
    check("pulse end", {wd_reset_pulse, chip_reset}, 2'b01);
    tick(DLY + 2);
    check("wd release", chip_reset, 1'b0);
    rd("wd flag", FL, 8'h08, 2'h0);
    rd("wd forced", CT, 8'h08, 2'h0);
    wr(CT, 8'h18, 2'h0);
    wr(CT, 8'h00, 2'h0);
    rd("wd held", CT, 8'h08, 2'h0);
    wr(FL, 8'h00, 2'h0);
    rd("wd kept", CT, 8'h08, 2'h0);
    wr(CT, 8'h18, 2'h0);
    wr(CT, 8'h00, 2'h0);
    rd("wd off", CT, 8'h00, 2'h0);
    // Interrupt mode, then interrupt with reset backup
    cpu_global_irq_enable <= 1'b1;
    wr(CT, 8'h40, 2'h0);
    restart();
    tick(WD0 + 2);
    check("irq only", {wd_reset_pulse, chip_reset}, 2'b00);
    check("irq req", wd_irq_request, 1'b1);
    rd("irq flag", CT, 8'hC0, 2'h0);
    irq_vector_taken <= 1'b1;
    tick(1);
    irq_vector_taken <= 1'b0;
    rd("vector clr", CT, 8'h40, 2'h0);
    wr(CT, 8'h48, 2'h0);
    restart();
    tick(WD0 + 2);
    check("irq first", chip_reset, 1'b0);
    rd("irq en clr", CT, 8'h88, 2'h0);
    wr(CT, 8'h88, 2'h0);
    rd("flag wr clr", CT, 8'h08, 2'h0);
    restart();
    tick(WD0 + 1);
    check("then reset", {wd_reset_pulse, chip_reset}, 2'b11);
    // Safety level 2
    aresetn <= 1'b0;
    safety_level_fuse <= 1'b1;
    tick(12);
    aresetn <= 1'b1;
    tick(1);
    rd("l2 flags", FL, 8'h01, 2'h0);
    rd("l2 ctrl", CT, 8'h08, 2'h0);
    wr(CT, 8'h02, 2'h0);
    rd("l2 hold", CT, 8'h08, 2'h0);
    wr(CT, 8'h18, 2'h0);
    wr(CT, 8'h03, 2'h0);
    rd("l2 seq", CT, 8'h0B, 2'h0);
    wrap_up();
  end
endmodule // watchdog_and_reset_flags_tb
